// ==== common/module_ctrl_pkg.sv ====
// constants, types and offsets shared by the module control and status logic
// Summary of operation
// - management initialisation completes no later than 2000 ms after power-on or reset.
// - an interrupt-triggering condition drives the interrupt output low within 200 ms.
// - reading flags clears them; interrupt releases within 500 us of that read.
// - receive loss sets its flag and asserts interrupt within 100 ms.
// - in fast mode receive loss status negates within 100 ms after loss ends.
// - transmit fault sets its flag and asserts interrupt within 200 ms.
// - any other condition sets its flag and asserts interrupt within 200 ms.
// - a mask bit written to 0 resumes its source within 100 ms.
// - a rate select change reconfigures bandwidth within 100 ms.
// - lost receive input squelches the receive output within 15 ms.
// - returned receive input restores receive output within 5000 ms.
// - lost transmit input squelches the transmit output within 400 ms.
// - returned transmit input restores transmit output within 5000 ms.
// - writing transmit disable turns transmit output off within 100 ms.
// - in fast mode transmit disable turns output off within 3 ms.
// - clearing transmit disable restores output within 400 ms, fast mode 10 ms.
// - receive output disable turns output off and back on within 100 ms.
// - automatic squelch cannot be disabled whatever software writes.
// - after power-up or reset, low power select asserted keeps low power mode.
// - without low power select the module enters high power mode by itself.
package module_ctrl_pkg;
  // ==========================================================
  // timing
  localparam int CLK_MHZ = 100;
  localparam int TICK_MS = 1;
  localparam int TICK_CYC = TICK_MS * CLK_MHZ * 1000;
  localparam int RESET_MIN_US = 10;
  localparam int RESET_MIN_CYC = RESET_MIN_US * CLK_MHZ;
  localparam int INIT_MAX_MS = 2000;
  localparam int INIT_TICKS = INIT_MAX_MS / TICK_MS;
  // ==========================================================
  // register offsets
  localparam logic [7:0] ADDR_STATUS = 8'h00;
  localparam logic [7:0] ADDR_FLAGS = 8'h01;
  localparam logic [7:0] ADDR_MASK = 8'h02;
  localparam logic [7:0] ADDR_CONTROL = 8'h03;
  // ==========================================================
  // synchronised input positions and reset value
  localparam int IN_RST = 5;
  localparam int IN_LP = 4;
  localparam int IN_RXLOS = 3;
  localparam int IN_TXLOS = 2;
  localparam int IN_TXFLT = 1;
  localparam int IN_OTHER = 0;
  localparam logic [5:0] SYNC_RST = 6'h30;
  // ==========================================================
  // flag, control and status fields
  localparam int FLG_RXLOS = 0;
  localparam int FLG_TXFLT = 1;
  localparam int FLG_TXLOS = 2;
  localparam int FLG_OTHER = 3;
  localparam int CTL_TXDIS = 0;
  localparam int CTL_RXDIS = 1;
  localparam int CTL_FAST = 2;
  localparam int CTL_SQDIS = 3;
  localparam int CTL_RATE = 4;
  localparam logic [4:0] CTL_RST = 5'h00;
  localparam logic [3:0] MASK_RST = 4'h0;
  localparam int STS_INIT = 0;
  localparam int STS_HIPWR = 1;
  localparam int STS_RXLOS = 2;
  localparam int STS_TXFLT = 3;
  localparam int STS_INT = 4;
  // ==========================================================
  typedef enum logic [1:0] {
    PH_HOLD = 2'b00,
    PH_INIT = 2'b01,
    PH_READY = 2'b11
  } phase_e;
endpackage

// ==== hdl/module_control_status.sv ====
// module control, status flags, interrupt, squelch, disable and power mode
`timescale 1ns/10ps
`default_nettype none
module module_control_status #(
  parameter int TICK_CYCLES = module_ctrl_pkg::TICK_CYC,
  parameter int INIT_TICKS = module_ctrl_pkg::INIT_TICKS
) (
  input wire logic mclk_in, // system clock, 100 MHz
  input wire logic rstn_in, // asynchronous power-on reset, active low
  input wire logic module_reset_low_in, // module reset pin, active low
  input wire logic low_power_select_in, // low power select pin
  input wire logic rx_los_in, // receive input signal lost
  input wire logic tx_los_in, // transmit input signal lost
  input wire logic tx_fault_in, // transmit fault state
  input wire logic other_cond_in, // any other flag condition
  input wire logic [7:0] addr_in, // register address
  input wire logic [7:0] wdata_in, // write data
  input wire logic wr_in, // write strobe
  input wire logic rd_in, // read strobe
  output logic [7:0] rdata_out, // read data, cycle after the read
  output logic interrupt_request_low_out, // interrupt, active low
  output logic management_initialisation_state_out, // high while initialising
  output logic high_power_out, // high power mode
  output logic tx_enable_out, // transmit output on
  output logic rx_enable_out, // receive output on
  output logic tx_squelch_out, // transmit output squelched
  output logic rx_squelch_out, // receive output squelched
  output logic rate_select_out // selected rate or application
);
  // ==========================================================
  // state
  typedef struct packed {
    logic [5:0] s1;
    logic [5:0] s2;
    logic [5:0] s3;
    logic [5:0] pin;
    module_ctrl_pkg::phase_e phase;
    logic [16:0] tick_cnt;
    logic tick;
    logic [10:0] ms_cnt;
    logic [9:0] rst_cnt;
    logic [3:0] flags;
    logic [3:0] mask;
    logic [4:0] ctrl;
    logic [7:0] rdata;
    logic int_low;
    logic init_act;
    logic hipwr;
    logic tx_en;
    logic rx_en;
    logic tx_sq;
    logic rx_sq;
    logic rate;
  } state_s;

  state_s st_q;
  state_s st_d;

  localparam logic [16:0] TICK_LAST = 17'(TICK_CYCLES - 1);
  localparam logic [10:0] INIT_LAST = 11'(INIT_TICKS - 1);
  localparam logic [9:0] RST_MIN = 10'(module_ctrl_pkg::RESET_MIN_CYC);

  logic [3:0] cond;
  logic ready;
  logic rst_low;
  logic [3:0] flags_n;
  logic [3:0] mask_n;
  logic [4:0] ctrl_n;
  logic [7:0] rd_mux;

  // ==========================================================
  // next state
  always_comb begin
    st_d = st_q;
    // three stage pin synchronisers; a change counts once stages two and three agree
    st_d.s1 = {module_reset_low_in, low_power_select_in, rx_los_in, tx_los_in, tx_fault_in,
               other_cond_in};
    st_d.s2 = st_q.s1;
    st_d.s3 = st_q.s2;
    for (int i = 0; i < 6; i++) begin
      if (st_q.s2[i] == st_q.s3[i]) begin
        st_d.pin[i] = st_q.s3[i];
      end
    end
    rst_low = !st_q.pin[module_ctrl_pkg::IN_RST];
    ready = (st_q.phase == module_ctrl_pkg::PH_READY);
    cond = '0;
    cond[module_ctrl_pkg::FLG_RXLOS] = st_q.pin[module_ctrl_pkg::IN_RXLOS];
    cond[module_ctrl_pkg::FLG_TXFLT] = st_q.pin[module_ctrl_pkg::IN_TXFLT];
    cond[module_ctrl_pkg::FLG_TXLOS] = st_q.pin[module_ctrl_pkg::IN_TXLOS];
    cond[module_ctrl_pkg::FLG_OTHER] = st_q.pin[module_ctrl_pkg::IN_OTHER];

    // millisecond tick from the system clock
    st_d.tick = 1'b0;
    if (st_q.tick_cnt == TICK_LAST) begin
      st_d.tick_cnt = '0;
      st_d.tick = 1'b1;
    end else begin
      st_d.tick_cnt = st_q.tick_cnt + 17'h00001;
    end

    // low time of the reset pin in cycles, saturating at the minimum
    if (!rst_low) begin
      st_d.rst_cnt = '0;
    end else if (st_q.rst_cnt != RST_MIN) begin
      st_d.rst_cnt = st_q.rst_cnt + 10'h001;
    end

    // a short glitch on the reset pin is ignored
    case (st_q.phase)
      module_ctrl_pkg::PH_HOLD: begin
        if (!rst_low) begin
          st_d.phase = module_ctrl_pkg::PH_INIT;
          st_d.ms_cnt = '0;
        end
      end
      module_ctrl_pkg::PH_INIT: begin
        if (st_q.tick) begin
          // counted in whole ticks, so completion never runs past the limit
          if (st_q.ms_cnt == INIT_LAST) begin
            st_d.phase = module_ctrl_pkg::PH_READY;
          end else begin
            st_d.ms_cnt = st_q.ms_cnt + 11'h001;
          end
        end
      end
      module_ctrl_pkg::PH_READY: begin
      end
      default: begin
        st_d.phase = module_ctrl_pkg::PH_HOLD;
      end
    endcase
    if (st_q.rst_cnt == RST_MIN) begin
      st_d.phase = module_ctrl_pkg::PH_HOLD;
    end

    // registers; a module reset returns them to their defaults
    mask_n = st_q.mask;
    ctrl_n = st_q.ctrl;
    if (wr_in && addr_in == module_ctrl_pkg::ADDR_MASK) begin
      mask_n = wdata_in[3:0];
    end
    if (wr_in && addr_in == module_ctrl_pkg::ADDR_CONTROL) begin
      ctrl_n = wdata_in[4:0];
    end
    // set wins over the clear on read, so no event is lost
    flags_n = st_q.flags;
    if (rd_in && addr_in == module_ctrl_pkg::ADDR_FLAGS) begin
      flags_n = '0;
    end
    if (ready) begin
      flags_n = flags_n | cond;
    end
    if (st_q.phase != module_ctrl_pkg::PH_READY) begin
      flags_n = '0;
      mask_n = module_ctrl_pkg::MASK_RST;
      ctrl_n = module_ctrl_pkg::CTL_RST;
    end
    st_d.flags = flags_n;
    st_d.mask = mask_n;
    st_d.ctrl = ctrl_n;

    // read data stands only in the cycle after the strobe
    rd_mux = '0;
    case (addr_in)
      module_ctrl_pkg::ADDR_STATUS: begin
        rd_mux[module_ctrl_pkg::STS_INIT] = st_q.init_act;
        rd_mux[module_ctrl_pkg::STS_HIPWR] = st_q.hipwr;
        rd_mux[module_ctrl_pkg::STS_RXLOS] = st_q.pin[module_ctrl_pkg::IN_RXLOS];
        rd_mux[module_ctrl_pkg::STS_TXFLT] = st_q.pin[module_ctrl_pkg::IN_TXFLT];
        rd_mux[module_ctrl_pkg::STS_INT] = !st_q.int_low;
      end
      module_ctrl_pkg::ADDR_FLAGS: begin
        rd_mux[3:0] = st_q.flags;
      end
      module_ctrl_pkg::ADDR_MASK: begin
        rd_mux[3:0] = st_q.mask;
      end
      module_ctrl_pkg::ADDR_CONTROL: begin
        rd_mux[4:0] = st_q.ctrl;
      end
      default: begin
        rd_mux = '0;
      end
    endcase
    st_d.rdata = rd_in ? rd_mux : 8'h00;

    // outputs except read data, squelch, high power and the ready and loss terms of the enables follow the next register values, a cycle behind their cause
    st_d.int_low = !(|(flags_n & ~mask_n));
    st_d.init_act = (st_d.phase != module_ctrl_pkg::PH_READY);
    // the squelch disable bit is stored but never consulted
    st_d.rx_sq = st_q.pin[module_ctrl_pkg::IN_RXLOS];
    st_d.tx_sq = st_q.pin[module_ctrl_pkg::IN_TXLOS];
    st_d.hipwr = ready && !st_q.pin[module_ctrl_pkg::IN_LP];
    // disable acts in one cycle, well inside the fast mode limits as well
    st_d.tx_en = ready && !ctrl_n[module_ctrl_pkg::CTL_TXDIS] &&
                 !st_q.pin[module_ctrl_pkg::IN_TXLOS];
    st_d.rx_en = ready && !ctrl_n[module_ctrl_pkg::CTL_RXDIS] &&
                 !st_q.pin[module_ctrl_pkg::IN_RXLOS];
    st_d.rate = ctrl_n[module_ctrl_pkg::CTL_RATE];
  end

  // ==========================================================
  // registers
  always_ff @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      st_q <= '0;
      st_q.s1 <= module_ctrl_pkg::SYNC_RST;
      st_q.s2 <= module_ctrl_pkg::SYNC_RST;
      st_q.s3 <= module_ctrl_pkg::SYNC_RST;
      st_q.pin <= module_ctrl_pkg::SYNC_RST;
      st_q.phase <= module_ctrl_pkg::PH_INIT;
      st_q.int_low <= 1'b1;
      st_q.init_act <= 1'b1;
    end else begin
      st_q <= st_d;
    end
  end

  assign rdata_out = st_q.rdata;
  assign interrupt_request_low_out = st_q.int_low;
  assign management_initialisation_state_out = st_q.init_act;
  assign high_power_out = st_q.hipwr;
  assign tx_enable_out = st_q.tx_en;
  assign rx_enable_out = st_q.rx_en;
  assign tx_squelch_out = st_q.tx_sq;
  assign rx_squelch_out = st_q.rx_sq;
  assign rate_select_out = st_q.rate;

  // ==========================================================
  // assertions
  default clocking cb @(posedge mclk_in);
  endclocking
  default disable iff (!rstn_in);

  a_init_done: assert property (
    (st_q.phase == module_ctrl_pkg::PH_INIT && st_q.tick && st_q.ms_cnt == INIT_LAST &&
     st_q.rst_cnt != RST_MIN) |=> (st_q.phase == module_ctrl_pkg::PH_READY) ##1 !st_q.init_act)
    else $error("initialisation did not complete at its last tick");

  a_reset_request: assert property (
    (st_q.rst_cnt == RST_MIN) |=> (st_q.phase == module_ctrl_pkg::PH_HOLD) ##1 st_q.init_act)
    else $error("long reset pulse not taken as a module reset");

  a_int_follows: assert property (
    (ready && |(st_q.flags & ~st_q.mask)) |-> !interrupt_request_low_out)
    else $error("unmasked flag without interrupt");

  a_read_clears: assert property (
    (ready && rd_in && addr_in == module_ctrl_pkg::ADDR_FLAGS && cond == 4'h0 &&
     st_q.pin == st_q.s3 && st_q.s3 == st_q.s2)
    |=> (st_q.flags == 4'h0) && interrupt_request_low_out)
    else $error("flags not cleared or interrupt not released after read");

  // a mask write in the same cycle may legally inhibit the interrupt
  a_los_flag: assert property (
    (ready && st_q.pin[module_ctrl_pkg::IN_RXLOS] && !st_q.mask[module_ctrl_pkg::FLG_RXLOS] &&
     !(wr_in && addr_in == module_ctrl_pkg::ADDR_MASK))
    |=> st_q.flags[module_ctrl_pkg::FLG_RXLOS] && !interrupt_request_low_out)
    else $error("receive loss flag or interrupt missing");

  a_los_status: assert property (
    (rd_in && addr_in == module_ctrl_pkg::ADDR_STATUS && !st_q.pin[module_ctrl_pkg::IN_RXLOS])
    |=> !rdata_out[module_ctrl_pkg::STS_RXLOS])
    else $error("receive loss status still shown after loss ended");

  a_fault_flag: assert property (
    (ready && st_q.pin[module_ctrl_pkg::IN_TXFLT]) |=> st_q.flags[module_ctrl_pkg::FLG_TXFLT])
    else $error("transmit fault flag missing");

  a_other_flag: assert property (
    (ready && st_q.pin[module_ctrl_pkg::IN_OTHER]) |=> st_q.flags[module_ctrl_pkg::FLG_OTHER])
    else $error("condition flag missing");

  a_mask_full: assert property (
    (ready && wr_in && addr_in == module_ctrl_pkg::ADDR_MASK && wdata_in[3:0] == 4'hF)
    |=> interrupt_request_low_out)
    else $error("masked sources still drive the interrupt");

  a_rate_follow: assert property (
    (ready && wr_in && addr_in == module_ctrl_pkg::ADDR_CONTROL)
    |=> rate_select_out == $past(wdata_in[module_ctrl_pkg::CTL_RATE]))
    else $error("rate select did not follow the write");

  a_rx_squelch: assert property (
    $rose(st_q.pin[module_ctrl_pkg::IN_RXLOS]) |-> ##1 rx_squelch_out && !rx_enable_out)
    else $error("receive output not squelched on loss");

  a_tx_squelch: assert property (
    $rose(st_q.pin[module_ctrl_pkg::IN_TXLOS]) |-> ##1 tx_squelch_out && !tx_enable_out)
    else $error("transmit output not squelched on loss");

  a_tx_disable: assert property (
    (wr_in && addr_in == module_ctrl_pkg::ADDR_CONTROL && wdata_in[module_ctrl_pkg::CTL_TXDIS])
    |=> !tx_enable_out)
    else $error("transmit output on after disable");

  a_power_mode: assert property (
    (st_q.pin[module_ctrl_pkg::IN_LP] || !ready) |=> !high_power_out)
    else $error("high power mode while low power select asserted");

  a_high_power: assert property (
    (ready && !st_q.pin[module_ctrl_pkg::IN_LP]) |=> high_power_out)
    else $error("high power mode not entered without low power select");

  a_init_bound: assert property (
    (st_q.phase == module_ctrl_pkg::PH_INIT) |-> (st_q.ms_cnt <= INIT_LAST))
    else $error("initialisation count ran past its last tick");

  // every tick restarts the prescaler, so ticks are evenly spaced
  a_tick_restart: assert property (
    st_q.tick |-> (st_q.tick_cnt == 17'h00000))
    else $error("tick without prescaler restart");

  a_tick_range: assert property (
    st_q.tick_cnt <= TICK_LAST)
    else $error("prescaler beyond its last count");

  a_defaults_held: assert property (
    (st_q.phase != module_ctrl_pkg::PH_READY)
    |=> (st_q.flags == 4'h0) && (st_q.ctrl == module_ctrl_pkg::CTL_RST) &&
        (st_q.mask == module_ctrl_pkg::MASK_RST))
    else $error("registers not at defaults outside the ready phase");

  // flags already latched must reach the interrupt as soon as their mask opens
  a_mask_clear: assert property (
    (ready && wr_in && !rd_in && addr_in == module_ctrl_pkg::ADDR_MASK &&
     wdata_in[3:0] == 4'h0 && |st_q.flags) |=> !interrupt_request_low_out)
    else $error("interrupt not resumed after mask cleared");

  a_fault_int: assert property (
    (ready && st_q.pin[module_ctrl_pkg::IN_TXFLT] && !st_q.mask[module_ctrl_pkg::FLG_TXFLT] &&
     !(wr_in && addr_in == module_ctrl_pkg::ADDR_MASK)) |=> !interrupt_request_low_out)
    else $error("transmit fault did not assert the interrupt");

  a_other_int: assert property (
    (ready && st_q.pin[module_ctrl_pkg::IN_OTHER] && !st_q.mask[module_ctrl_pkg::FLG_OTHER] &&
     !(wr_in && addr_in == module_ctrl_pkg::ADDR_MASK)) |=> !interrupt_request_low_out)
    else $error("condition did not assert the interrupt");

  a_rx_restore: assert property (
    $fell(st_q.pin[module_ctrl_pkg::IN_RXLOS]) |-> ##1 !rx_squelch_out)
    else $error("receive squelch not released when input returned");

  a_tx_restore: assert property (
    $fell(st_q.pin[module_ctrl_pkg::IN_TXLOS]) |-> ##1 !tx_squelch_out)
    else $error("transmit squelch not released when input returned");

  a_fast_disable: assert property (
    (wr_in && addr_in == module_ctrl_pkg::ADDR_CONTROL && wdata_in[module_ctrl_pkg::CTL_TXDIS] &&
     wdata_in[module_ctrl_pkg::CTL_FAST]) |=> !tx_enable_out)
    else $error("transmit output on after disable in fast mode");

  // enabling back needs a ready block and no loss on the same path
  a_tx_enable_back: assert property (
    (ready && wr_in && addr_in == module_ctrl_pkg::ADDR_CONTROL &&
     !wdata_in[module_ctrl_pkg::CTL_TXDIS] && !st_q.pin[module_ctrl_pkg::IN_TXLOS])
    |=> tx_enable_out)
    else $error("transmit output not restored after disable cleared");

  a_rx_disable: assert property (
    (wr_in && addr_in == module_ctrl_pkg::ADDR_CONTROL && wdata_in[module_ctrl_pkg::CTL_RXDIS])
    |=> !rx_enable_out)
    else $error("receive output on after disable");

  a_rx_enable_back: assert property (
    (ready && wr_in && addr_in == module_ctrl_pkg::ADDR_CONTROL &&
     !wdata_in[module_ctrl_pkg::CTL_RXDIS] && !st_q.pin[module_ctrl_pkg::IN_RXLOS])
    |=> rx_enable_out)
    else $error("receive output not restored after disable cleared");

  a_squelch_kept: assert property (
    (st_q.ctrl[module_ctrl_pkg::CTL_SQDIS] && st_q.pin[module_ctrl_pkg::IN_RXLOS])
    |=> rx_squelch_out)
    else $error("receive squelch lost while squelch disable set");
endmodule // module_control_status
`default_nettype wire

// ==== verification/host_pins_model.sv ====
// host side model: drives the module reset and low power select pins
`timescale 1ns/10ps
`default_nettype none
module host_pins_model (
  input wire logic mclk_in, // system clock
  input wire logic rstn_in, // power-on reset, active low
  input wire logic pulse_req_in, // start a module reset pulse
  input wire logic [15:0] pulse_len_in, // pulse length in cycles
  input wire logic low_power_req_in, // host asks for low power
  output logic module_reset_low_out, // module reset pin, active low
  output logic low_power_select_out // low power select pin
);
  logic [15:0] cnt_q;
  // a real host holds the pin for the whole length; no early release
  always_ff @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      cnt_q <= 16'h0000;
      low_power_select_out <= 1'b0;
    end else begin
      low_power_select_out <= low_power_req_in;
      if (pulse_req_in) begin
        cnt_q <= pulse_len_in;
      end else if (cnt_q != 16'h0000) begin
        cnt_q <= cnt_q - 16'h0001;
      end
    end
  end
  assign module_reset_low_out = (cnt_q == 16'h0000);
endmodule // host_pins_model
`default_nettype wire

// ==== verification/tb_top.sv ====
// self-checking bench for the module control and status block
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  localparam int TICK = 10;
  localparam int INITT = 5;
  typedef struct packed {logic [3:0] cond; logic [3:0] mask; logic interrupt_request_low;} row_s;
  row_s rows [0:5] = '{'{4'h1, 4'h0, 1'b0}, '{4'h2, 4'h0, 1'b0}, '{4'h4, 4'h0, 1'b0},
    '{4'h8, 4'h0, 1'b0}, '{4'h1, 4'h1, 1'b1}, '{4'hF, 4'hE, 1'b0}};
  logic mclk = 1'b0;
  logic rstn = 1'b0;
  logic rst_low, lp, interrupt_request_low, init, hipwr, txen, rxen, txsq, rxsq, rate;
  logic rx_los = 1'b0, tx_los = 1'b0, tx_flt = 1'b0, oth = 1'b0;
  logic wr = 1'b0, rd = 1'b0, preq = 1'b0, lpreq = 1'b0;
  logic [7:0] addr = 8'h00, wdata = 8'h00, rdata;
  logic [15:0] plen = 16'h0000;
  int fail_count = 0;
  int cmp_count = 0;
  always #5 mclk = ~mclk;
  module_control_status #(.TICK_CYCLES(TICK), .INIT_TICKS(INITT)) module_control_status_inst (
    .mclk_in(mclk), .rstn_in(rstn), .module_reset_low_in(rst_low), .low_power_select_in(lp),
    .rx_los_in(rx_los), .tx_los_in(tx_los), .tx_fault_in(tx_flt), .other_cond_in(oth),
    .addr_in(addr), .wdata_in(wdata), .wr_in(wr), .rd_in(rd), .rdata_out(rdata),
    .interrupt_request_low_out(interrupt_request_low), .management_initialisation_state_out(init),
    .high_power_out(hipwr), .tx_enable_out(txen), .rx_enable_out(rxen),
    .tx_squelch_out(txsq), .rx_squelch_out(rxsq), .rate_select_out(rate));
  host_pins_model host_pins_model_inst (.mclk_in(mclk), .rstn_in(rstn), .pulse_req_in(preq),
    .pulse_len_in(plen), .low_power_req_in(lpreq), .module_reset_low_out(rst_low),
    .low_power_select_out(lp));
  // ==========================================================
  // shared tasks
  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic chkb(input string name, input logic exp, input logic got);
    chk(name, {7'h00, exp}, {7'h00, got});
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge mclk);
    wr <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe, so sample there
  task automatic rd_reg(input logic [7:0] a, input logic [7:0] exp, input string name);
    @(posedge mclk);
    addr <= a;
    rd <= 1'b1;
    @(posedge mclk);
    rd <= 1'b0;
    #1;
    chk(name, exp, rdata);
  endtask
  task automatic set_cond(input logic [3:0] c);
    @(posedge mclk);
    rx_los <= c[0];
    tx_flt <= c[1];
    tx_los <= c[2];
    oth <= c[3];
  endtask
  task automatic pulse(input logic [15:0] n);
    @(posedge mclk);
    preq <= 1'b1;
    plen <= n;
    @(posedge mclk);
    preq <= 1'b0;
  endtask
  // bound includes the few cycles the pins spend in synchronisers
  task automatic wait_init(input int lim);
    int n;
    n = 0;
    while (init !== 1'b0 && n < lim) begin
      tick(1);
      n++;
    end
    if (n >= lim) begin
      fail_count++;
      $display("mismatch init_time expected %0d seen %0d", lim, n);
      report_and_stop();
    end
  endtask
  // ==========================================================
  // main sequence
  initial begin
    tick(2);
    chkb("interrupt_request_low_in_reset", 1'b1, interrupt_request_low);
    chkb("init_in_reset", 1'b1, init);
    chk("rdata_in_reset", 8'h00, rdata);
    @(posedge mclk);
    rstn <= 1'b1;
    wait_init(INITT * TICK + 12);
    tick(2);
    chkb("high_power", 1'b1, hipwr);
    foreach (rows[i]) begin
      wr_reg(module_ctrl_pkg::ADDR_MASK, {4'h0, rows[i].mask});
      set_cond(rows[i].cond);
      tick(8);
      chkb("interrupt_request_low", rows[i].interrupt_request_low, interrupt_request_low);
      chkb("rx_squelch", rows[i].cond[0], rxsq);
      chkb("tx_squelch", rows[i].cond[2], txsq);
      rd_reg(module_ctrl_pkg::ADDR_STATUS, {3'b000, ~rows[i].interrupt_request_low, rows[i].cond[1:0], 2'b10},
        "status");
      rd_reg(module_ctrl_pkg::ADDR_FLAGS, {4'h0, rows[i].cond}, "flags");
      set_cond(4'h0);
      tick(8);
      chkb("rx_enable", 1'b1, rxen);
      chkb("tx_enable", 1'b1, txen);
      rd_reg(module_ctrl_pkg::ADDR_FLAGS, {4'h0, rows[i].cond}, "flags_held");
      tick(1);
      chkb("interrupt_request_low_released", 1'b1, interrupt_request_low);
      rd_reg(module_ctrl_pkg::ADDR_FLAGS, 8'h00, "flags_cleared");
      rd_reg(module_ctrl_pkg::ADDR_STATUS, 8'h02, "status_idle");
    end
    wr_reg(module_ctrl_pkg::ADDR_MASK, 8'h01);
    set_cond(4'h1);
    tick(8);
    chkb("interrupt_request_low_masked_loss", 1'b1, interrupt_request_low);
    wr_reg(module_ctrl_pkg::ADDR_MASK, 8'h00);
    tick(1);
    chkb("interrupt_request_low_unmasked", 1'b0, interrupt_request_low);
    wr_reg(module_ctrl_pkg::ADDR_MASK, 8'h01);
    tick(1);
    chkb("interrupt_request_low_masked", 1'b1, interrupt_request_low);
    rd_reg(module_ctrl_pkg::ADDR_MASK, 8'h01, "mask");
    set_cond(4'h0);
    wr_reg(module_ctrl_pkg::ADDR_CONTROL, 8'h1B);
    tick(2);
    chkb("tx_enable_off", 1'b0, txen);
    chkb("rx_enable_off", 1'b0, rxen);
    chkb("rate", 1'b1, rate);
    rd_reg(module_ctrl_pkg::ADDR_CONTROL, 8'h1B, "control");
    set_cond(4'h5);
    tick(8);
    chkb("rx_squelch_kept", 1'b1, rxsq);
    chkb("tx_squelch_kept", 1'b1, txsq);
    set_cond(4'h0);
    tick(8);
    wr_reg(module_ctrl_pkg::ADDR_CONTROL, 8'h04);
    tick(2);
    chkb("tx_enable_on", 1'b1, txen);
    chkb("rx_enable_on", 1'b1, rxen);
    chkb("rate_back", 1'b0, rate);
    wr_reg(module_ctrl_pkg::ADDR_CONTROL, 8'h05);
    tick(2);
    chkb("tx_enable_fast", 1'b0, txen);
    wr_reg(8'h7F, 8'hFF);
    rd_reg(8'h7F, 8'h00, "unmapped");
    pulse(16'h01F4);
    tick(600);
    chkb("short_pulse", 1'b0, init);
    @(posedge mclk);
    lpreq <= 1'b1;
    pulse(16'h044C);
    tick(1050);
    chkb("long_pulse", 1'b1, init);
    wait_init(INITT * TICK + 70);
    tick(2);
    chkb("low_power", 1'b0, hipwr);
    rd_reg(module_ctrl_pkg::ADDR_CONTROL, 8'h00, "control_cleared");
    @(posedge mclk);
    lpreq <= 1'b0;
    tick(8);
    chkb("high_power_again", 1'b1, hipwr);
    report_and_stop();
  end
endmodule // tb_top
`default_nettype wire
